// >>> logic/radio_ctrl_map.vh
// register map, field positions and constants for the radio control block
`ifndef RADIO_CTRL_MAP_VH
`define RADIO_CTRL_MAP_VH
`define IDX_OCP 8'h13
`define IDX_TUNE_A 8'h5a
`define IDX_TUNE_B 8'h5c
`define IDX_FDEV 8'h05
`define IDX_SHAPING 8'h12
`define IDX_AMP_LEVEL 8'h11
`define IDX_FRONT_END 8'h18
`define IDX_RX_CTRL 8'h3d
`define IDX_RSSI_LIMIT 8'h29
`define IDX_RSSI_VALUE 8'h24
`define IDX_MODE 8'h02
`define IDX_TX_STATUS 8'h70
`define RST_OCP 8'h1a
`define RST_TUNE_A 8'h55
`define RST_TUNE_B 8'h70
`define RST_FDEV 14'h0052
`define RST_AMP_LEVEL 8'h9f
`define RST_FRONT_END 8'h08
`define RST_RSSI_LIMIT 8'he4
`define RST_SHAPING 8'h09
`define RST_RX_CTRL 8'h02
`define RST_MODE 8'h00
`define BIT_PERIOD 16'h0010
`define HP_TUNE_A 8'h5d
`define HP_TUNE_B 8'h7c
`define BASE_SINGLE 8'hee
`define BASE_COMBINED 8'hf2
`define BASE_HIGH 8'hf5
`define OCP_BASE_MA 8'h2d
`define OCP_STEP_MA 8'h05
`define OCP_ON_BIT 4
`define LNA_ZIN_BIT 7
`define GAIN_AUTO 3'h0
`define GAIN_RESERVED 3'h7
`define GAIN_MAX 3'h1
`define GAIN_MIN 3'h6
`define REARM_BIT 2
`define AUTO_REARM_BIT 1
`define SYNTH_FRAC_BITS 19
`endif

// >>> logic/gain_search.v
// automatic front-end gain search: wait, freeze, re-arm
`timescale 1ns/10ps
`include "radio_ctrl_map.vh"
module gain_search
(
    input wire pclk,
    input wire presetn,
    input wire rx_enable,
    input wire packet_mode,
    input wire [2:0] gain_choice,
    input wire [7:0] rssi_value,
    input wire [7:0] rssi_limit,
    input wire rssi_strobe,
    input wire rearm_pulse,
    input wire auto_rearm,
    input wire fifo_empty,
    input wire packet_done,
    input wire [3:0] gap_sel,
    output reg [2:0] gain_q,
    output reg waiting_q
);
    localparam ST_IDLE = 2'd0;
    localparam ST_WAIT = 2'd1;
    localparam ST_HOLD = 2'd2;
    localparam ST_GAP = 2'd3;
    reg [1:0] state_q;
    reg hit_q;
    reg [15:0] gap_q;
    reg pending_q;
    wire [7:0] margin = rssi_limit - rssi_value;
    reg [2:0] best;
    always @*
    begin
        // rssi more negative means weaker; pick less gain for stronger signal
        if (margin >= 8'd60) best = `GAIN_MIN;
        else if (margin >= 8'd48) best = 3'h5;
        else if (margin >= 8'd36) best = 3'h4;
        else if (margin >= 8'd24) best = 3'h3;
        else if (margin >= 8'd12) best = 3'h2;
        else best = `GAIN_MAX;
    end
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= ST_IDLE;
            hit_q <= 1'b0;
            gap_q <= 16'h0000;
            pending_q <= 1'b0;
            gain_q <= `GAIN_MAX;
            waiting_q <= 1'b0;
        end
        else if (!rx_enable)
        begin
            state_q <= ST_IDLE;
            hit_q <= 1'b0;
            pending_q <= 1'b0;
            waiting_q <= 1'b0;
        end
        else if (gain_choice != `GAIN_AUTO)
        begin
            if (gain_choice != `GAIN_RESERVED)
                gain_q <= gain_choice;
            state_q <= ST_WAIT;
            waiting_q <= 1'b1;
        end
        else if (rearm_pulse)
        begin
            state_q <= ST_WAIT;
            hit_q <= 1'b0;
            pending_q <= 1'b0;
            waiting_q <= 1'b1;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    state_q <= ST_WAIT;
                    waiting_q <= 1'b1;
                end
                ST_WAIT:
                begin
                    // rssi is -value/2; exceeding the limit means smaller code
                    if (rssi_strobe)
                    begin
                        hit_q <= rssi_value < rssi_limit;
                        if (hit_q && rssi_value < rssi_limit)
                        begin
                            gain_q <= best;
                            state_q <= ST_HOLD;
                            waiting_q <= 1'b0;
                            hit_q <= 1'b0;
                        end
                    end
                end
                ST_HOLD:
                begin
                    // gain stays frozen until a re-arm condition
                    if (pending_q && fifo_empty)
                    begin
                        pending_q <= 1'b0;
                        state_q <= ST_GAP;
                        gap_q <= 16'h0001 << gap_sel;
                    end
                    // a packet end in the same cycle wins over the clear
                    if (packet_done && packet_mode && auto_rearm)
                        pending_q <= 1'b1;
                end
                ST_GAP:
                begin
                    if (gap_q == 16'h0001)
                    begin
                        state_q <= ST_WAIT;
                        waiting_q <= 1'b1;
                    end
                    gap_q <= gap_q - 16'h0001;
                end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end
endmodule // gain_search

// >>> logic/tx_shaper.v
// transmit keying, ook ramp and bit clock request
`timescale 1ns/10ps
`include "radio_ctrl_map.vh"
module tx_shaper #(
    parameter RAMP_W = 4
)
(
    input wire pclk,
    input wire presetn,
    input wire tx_enable,
    input wire ook_mode,
    input wire continuous,
    input wire [1:0] shaping,
    input wire [15:0] bit_period,
    input wire data_in,
    output reg bit_req_q,
    output reg tx_bit_q,
    output reg [RAMP_W-1:0] bias_q
);
    localparam [RAMP_W-1:0] BIAS_FULL = {RAMP_W{1'b1}};
    localparam [RAMP_W-1:0] BIAS_ONE = {{(RAMP_W-1){1'b0}}, 1'b1};
    reg [15:0] cnt_q;
    wire tick = (cnt_q == 16'h0000);
    wire gauss = !ook_mode && (shaping != 2'b00);
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_q <= 16'h0000;
            bit_req_q <= 1'b0;
            tx_bit_q <= 1'b0;
            bias_q <= {RAMP_W{1'b0}};
        end
        else
        begin
            bit_req_q <= 1'b0;
            if (!tx_enable)
            begin
                cnt_q <= 16'h0000;
                bias_q <= {RAMP_W{1'b0}};
            end
            else
            begin
                cnt_q <= tick ? bit_period : cnt_q - 16'h0001;
                if (continuous && gauss)
                begin
                    // sample bit each period and ask the host for the next
                    if (tick)
                    begin
                        tx_bit_q <= data_in;
                        bit_req_q <= 1'b1;
                    end
                end
                else
                    tx_bit_q <= data_in;
                if (!ook_mode)
                    bias_q <= BIAS_FULL;
                else if (shaping == 2'b00)
                    bias_q <= data_in ? BIAS_FULL : {RAMP_W{1'b0}};
                else if (data_in && bias_q != BIAS_FULL)
                    bias_q <= bias_q + BIAS_ONE;
                else if (!data_in && bias_q != {RAMP_W{1'b0}})
                    bias_q <= bias_q - BIAS_ONE;
            end
        end
    end
endmodule // tx_shaper

// >>> logic/radio_ctrl.v
// apb register file, amplifier path, power and current clamp control
// Behaviour
// - deviation equals synth_step times 14-bit freq_deviation_word, via fractional divider
// - ook keys the amplifier on for one data level, off for other
// - fsk shaping selects gaussian bt 0.3, 0.5 or 1 before modulator
// - continuous gaussian mode pulses bit_clock_out per bit; host presents next bit
// - ook with shaping ramps amplifier bias smoothly on and off
// - amplifier enables 100, 010, 011 select paths; others reserved
// - power is -18, -14 or -11 dBm plus output_power_level by path
// - amplifier current clamped at 45 plus 5 times current_limit_trim mA
// - lna_impedance_sel picks 50 or 200 ohm input
// - front_gain_choice 000 auto, 001-110 fixed gains, 111 reserved
// - wait until rssi exceeds limit twice, then pick best gain
// - applied_front_gain readable and held until re-arm
// - packet mode without auto rearm keeps gain for next packet
// - auto rearm waits fifo empty, then rearm_gap, then waiting
// - writing receive_rearm restarts the gain search
// - synth_step is reference over two to the nineteenth
//
// The APB slave port is this design's own decision.
`timescale 1ns/10ps
`include "radio_ctrl_map.vh"
module radio_ctrl #(
    parameter RAMP_W = 4
)
(
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire tx_enable,
    input wire rx_enable,
    input wire data_in,
    input wire [7:0] rssi_value,
    input wire rssi_strobe,
    input wire fifo_empty,
    input wire packet_done,
    output reg bit_clock_out,
    output reg tx_data_out,
    output reg [RAMP_W-1:0] pa_bias,
    output reg rf_io_pin_en,
    output reg boost_a_en,
    output reg boost_b_en,
    output reg [7:0] pout_dbm,
    output reg [7:0] current_limit_ma,
    output reg current_clamp_en,
    output reg [13:0] freq_deviation_word,
    output reg [1:0] gauss_bt_sel,
    output reg lna_impedance_sel,
    output reg [2:0] applied_front_gain,
    output reg rx_waiting
);
    reg [7:0] ocp_q;
    reg [7:0] tune_a_q;
    reg [7:0] tune_b_q;
    reg [13:0] fdev_q;
    reg [7:0] shaping_q;
    reg [7:0] amp_q;
    reg [7:0] front_q;
    reg [7:0] rxc_q;
    reg [7:0] rlim_q;
    reg [7:0] mode_q;
    reg rearm_q;
    wire [2:0] gain_w;
    wire wait_w;
    wire req_w;
    wire bit_w;
    wire [RAMP_W-1:0] bias_w;
    wire [7:0] idx = paddr[9:2];
    wire wr = psel && penable && pwrite;
    wire rd = psel && penable && !pwrite;
    // register index decode, shared by read and write paths
    function mapped;
        input [7:0] i;
        begin
            case (i)
                `IDX_OCP, `IDX_TUNE_A, `IDX_TUNE_B, `IDX_FDEV, `IDX_SHAPING,
                `IDX_AMP_LEVEL, `IDX_FRONT_END, `IDX_RX_CTRL, `IDX_RSSI_LIMIT,
                `IDX_RSSI_VALUE, `IDX_MODE, `IDX_TX_STATUS: mapped = 1'b1;
                default: mapped = 1'b0;
            endcase
        end
    endfunction
    wire bad = (paddr[1:0] != 2'b00) || (paddr[11:10] != 2'b00) || !mapped(idx);
    wire high_power = (tune_a_q == `HP_TUNE_A) && (tune_b_q == `HP_TUNE_B);
    wire [2:0] pa_sel = amp_q[7:5];
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ocp_q <= `RST_OCP;
            tune_a_q <= `RST_TUNE_A;
            tune_b_q <= `RST_TUNE_B;
            fdev_q <= `RST_FDEV;
            shaping_q <= `RST_SHAPING;
            amp_q <= `RST_AMP_LEVEL;
            front_q <= `RST_FRONT_END;
            rxc_q <= `RST_RX_CTRL;
            rlim_q <= `RST_RSSI_LIMIT;
            mode_q <= `RST_MODE;
            rearm_q <= 1'b0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            rearm_q <= 1'b0;
            pready <= psel && !penable;
            pslverr <= psel && !penable && bad;
            if (wr && pready && !bad)
            begin
                case (idx)
                    `IDX_OCP: ocp_q <= pwdata[7:0];
                    `IDX_TUNE_A: tune_a_q <= pwdata[7:0];
                    `IDX_TUNE_B: tune_b_q <= pwdata[7:0];
                    `IDX_FDEV: fdev_q <= pwdata[13:0];
                    `IDX_SHAPING: shaping_q <= pwdata[7:0];
                    `IDX_AMP_LEVEL: amp_q <= pwdata[7:0];
                    `IDX_FRONT_END: front_q <= {pwdata[7], pwdata[6:3], 3'h0};
                    `IDX_RX_CTRL:
                    begin
                        rxc_q <= {pwdata[7:3], 1'b0, pwdata[1:0]};
                        rearm_q <= pwdata[`REARM_BIT];
                    end
                    `IDX_RSSI_LIMIT: rlim_q <= pwdata[7:0];
                    `IDX_MODE: mode_q <= pwdata[7:0];
                    default: mode_q <= mode_q;
                endcase
            end
            if (psel && !penable)
            begin
                case (idx)
                    `IDX_OCP: prdata <= {24'h0, ocp_q};
                    `IDX_TUNE_A: prdata <= {24'h0, tune_a_q};
                    `IDX_TUNE_B: prdata <= {24'h0, tune_b_q};
                    `IDX_FDEV: prdata <= {18'h0, fdev_q};
                    `IDX_SHAPING: prdata <= {24'h0, shaping_q};
                    `IDX_AMP_LEVEL: prdata <= {24'h0, amp_q};
                    `IDX_FRONT_END: prdata <= {24'h0, front_q[7:3], gain_w};
                    `IDX_RX_CTRL: prdata <= {24'h0, rxc_q};
                    `IDX_RSSI_LIMIT: prdata <= {24'h0, rlim_q};
                    `IDX_RSSI_VALUE: prdata <= {24'h0, rssi_value};
                    `IDX_MODE: prdata <= {24'h0, mode_q};
                    `IDX_TX_STATUS: prdata <= {30'h0, wait_w, bit_w};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
            else if (rd)
                prdata <= prdata;
        end
    end
    gain_search u_gain
    (
        .pclk(pclk),
        .presetn(presetn),
        .rx_enable(rx_enable),
        .packet_mode(!mode_q[0]),
        .gain_choice(front_q[5:3]),
        .rssi_value(rssi_value),
        .rssi_limit(rlim_q),
        .rssi_strobe(rssi_strobe),
        .rearm_pulse(rearm_q),
        .auto_rearm(rxc_q[`AUTO_REARM_BIT]),
        .fifo_empty(fifo_empty),
        .packet_done(packet_done),
        .gap_sel(rxc_q[7:4]),
        .gain_q(gain_w),
        .waiting_q(wait_w)
    );
    tx_shaper #(.RAMP_W(RAMP_W)) u_tx
    (
        .pclk(pclk),
        .presetn(presetn),
        .tx_enable(tx_enable),
        .ook_mode(mode_q[1]),
        .continuous(mode_q[0]),
        .shaping(shaping_q[6:5]),
        .bit_period(`BIT_PERIOD),
        .data_in(data_in),
        .bit_req_q(req_w),
        .tx_bit_q(bit_w),
        .bias_q(bias_w)
    );
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bit_clock_out <= 1'b0;
            tx_data_out <= 1'b0;
            pa_bias <= {RAMP_W{1'b0}};
            rf_io_pin_en <= 1'b0;
            boost_a_en <= 1'b0;
            boost_b_en <= 1'b0;
            pout_dbm <= 8'h00;
            current_limit_ma <= `OCP_BASE_MA;
            current_clamp_en <= 1'b0;
            freq_deviation_word <= `RST_FDEV;
            gauss_bt_sel <= 2'b00;
            lna_impedance_sel <= 1'b0;
            applied_front_gain <= `GAIN_MAX;
            rx_waiting <= 1'b0;
        end
        else
        begin
            bit_clock_out <= req_w;
            tx_data_out <= bit_w;
            pa_bias <= bias_w;
            // 100 main path, 010 booster a, 011 both boosters
            rf_io_pin_en <= tx_enable && pa_sel == 3'b100;
            boost_a_en <= tx_enable && pa_sel[2:1] == 2'b01;
            boost_b_en <= tx_enable && pa_sel == 3'b011;
            case (pa_sel)
                3'b100, 3'b010: pout_dbm <= `BASE_SINGLE + {3'h0, amp_q[4:0]};
                3'b011: pout_dbm <= (high_power ? `BASE_HIGH : `BASE_COMBINED)
                    + {3'h0, amp_q[4:0]};
                default: pout_dbm <= 8'h00;
            endcase
            current_limit_ma <= `OCP_BASE_MA + {4'h0, ocp_q[3:0]} * `OCP_STEP_MA;
            current_clamp_en <= ocp_q[`OCP_ON_BIT];
            freq_deviation_word <= fdev_q;
            gauss_bt_sel <= mode_q[1] ? 2'b00 : shaping_q[6:5];
            lna_impedance_sel <= front_q[`LNA_ZIN_BIT];
            applied_front_gain <= gain_w;
            rx_waiting <= wait_w;
        end
    end
endmodule // radio_ctrl

// >>> verif/radio_ctrl_monitor.sv
// assertion checker for the radio control block
`timescale 1ns/10ps
module radio_ctrl_monitor
(
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    input wire pslverr,
    input wire tx_enable,
    input wire bit_clock_out,
    input wire rf_io_pin_en,
    input wire boost_a_en,
    input wire boost_b_en,
    input wire [7:0] current_limit_ma,
    input wire current_clamp_en,
    input wire [13:0] freq_deviation_word,
    input wire [2:0] applied_front_gain
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    reg wr_q;
    reg [11:0] wa_q;
    reg [31:0] wd_q;
    // last completed write
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            wr_q <= 1'b0;
        else
            wr_q <= psel && penable && pready && pwrite;
    end
    always @(posedge pclk)
    begin
        wa_q <= paddr;
        wd_q <= pwdata;
    end
    a_ready_latency: assert property ($rose(penable) && psel |-> ##[0:1] pready)
        else $error("access not answered");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held");
    a_unmapped_error: assert property (psel && penable && pready && paddr == 12'h3fc |-> pslverr)
        else $error("unmapped access accepted");
    a_clamp_limit: assert property (wr_q && wa_q == 12'h04c |->
        ##[0:1] current_limit_ma == 8'h2d + 8'h05 * {4'h0, wd_q[3:0]})
        else $error("clamp limit wrong");
    a_clamp_enable: assert property (wr_q && wa_q == 12'h04c |->
        ##[0:1] current_clamp_en == wd_q[4])
        else $error("clamp enable wrong");
    a_deviation_load: assert property (wr_q && wa_q == 12'h014 |->
        ##[0:1] freq_deviation_word == wd_q[13:0])
        else $error("deviation not loaded");
    a_gain_legal: assert property (applied_front_gain != 3'h0 && applied_front_gain != 3'h7)
        else $error("reserved gain applied");
    a_path_legal: assert property (boost_b_en |-> boost_a_en && !rf_io_pin_en)
        else $error("reserved path");
    a_path_idle: assert property (!tx_enable |=> !rf_io_pin_en && !boost_a_en && !boost_b_en)
        else $error("path on while idle");
    a_bitclk_pulse: assert property (bit_clock_out |=> !bit_clock_out [*8])
        else $error("bit clock too fast");
endmodule // radio_ctrl_monitor
bind radio_ctrl radio_ctrl_monitor i_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .tx_enable(tx_enable), .bit_clock_out(bit_clock_out),
    .rf_io_pin_en(rf_io_pin_en), .boost_a_en(boost_a_en), .boost_b_en(boost_b_en),
    .current_limit_ma(current_limit_ma), .current_clamp_en(current_clamp_en),
    .freq_deviation_word(freq_deviation_word), .applied_front_gain(applied_front_gain));

// >>> verif/host_bit_feeder.sv
// host model feeding transmit bits on bit clock requests
`timescale 1ns/10ps
module host_bit_feeder
(
    input wire pclk,
    input wire presetn,
    input wire bit_clock_out,
    input wire stream_en,
    input wire level,
    output wire data_in
);
    reg [7:0] pat_q;
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pat_q <= 8'hb4;
        else if (bit_clock_out)
            pat_q <= {pat_q[6:0], pat_q[7]};
    end
    assign data_in = stream_en ? pat_q[7] : level;
endmodule // host_bit_feeder

// >>> verif/test_radio_ctrl.sv
// self-checking bench for the radio control block
`timescale 1ns/10ps
module test_radio_ctrl;
    reg pclk = 1'b0;
    reg presetn = 1'b0;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h0;
    reg tx_enable = 1'b0;
    reg rx_enable = 1'b0;
    reg [7:0] rssi_value = 8'h00;
    reg rssi_strobe = 1'b0;
    reg fifo_empty = 1'b0;
    reg packet_done = 1'b0;
    reg stream_en = 1'b0;
    reg level = 1'b0;
    wire data_in;
    wire [31:0] prdata;
    wire pready;
    wire pslverr;
    wire bit_clock_out;
    wire tx_data_out;
    wire [3:0] pa_bias;
    wire rf_io_pin_en;
    wire boost_a_en;
    wire boost_b_en;
    wire [7:0] pout_dbm;
    wire [7:0] current_limit_ma;
    wire current_clamp_en;
    wire [13:0] freq_deviation_word;
    wire [1:0] gauss_bt_sel;
    wire lna_impedance_sel;
    wire [2:0] applied_front_gain;
    wire rx_waiting;
    reg [31:0] rdata;
    reg rerr;
    reg mid;
    reg b;
    integer n_fail = 0;
    integer cmp_count = 0;
    integer n;
    integer k;
    always #5 pclk = ~pclk;
    radio_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tx_enable(tx_enable), .rx_enable(rx_enable), .data_in(data_in),
        .rssi_value(rssi_value), .rssi_strobe(rssi_strobe), .fifo_empty(fifo_empty),
        .packet_done(packet_done), .bit_clock_out(bit_clock_out), .tx_data_out(tx_data_out),
        .pa_bias(pa_bias), .rf_io_pin_en(rf_io_pin_en), .boost_a_en(boost_a_en),
        .boost_b_en(boost_b_en), .pout_dbm(pout_dbm), .current_limit_ma(current_limit_ma),
        .current_clamp_en(current_clamp_en), .freq_deviation_word(freq_deviation_word),
        .gauss_bt_sel(gauss_bt_sel), .lna_impedance_sel(lna_impedance_sel),
        .applied_front_gain(applied_front_gain), .rx_waiting(rx_waiting));
    host_bit_feeder i_host (.pclk(pclk), .presetn(presetn), .bit_clock_out(bit_clock_out),
        .stream_en(stream_en), .level(level), .data_in(data_in));
    task complete_run;
    begin
        $display("compares %0d failures %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    end
    endtask
    task give_up;
    begin
        n_fail = n_fail + 1;
        complete_run;
    end
    endtask
    task check(input string what, input [31:0] exp, input [31:0] got);
    begin
        cmp_count = cmp_count + 1;
        if (got !== exp)
        begin
            n_fail = n_fail + 1;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    end
    endtask
    task apb(input w, input [7:0] idx, input [31:0] wd);
    begin
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        @(posedge pclk);
        while (pready !== 1'b1)
        begin
            n = n + 1;
            if (n > 20)
                give_up;
            @(posedge pclk);
        end
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    end
    endtask
    task wait_edges(input integer lim);
    begin
        n = 0;
        @(posedge pclk);
        while (bit_clock_out !== 1'b1)
        begin
            n = n + 1;
            if (n > lim)
                give_up;
            @(posedge pclk);
        end
    end
    endtask
    task ramp(input [3:0] tgt);
    begin
        mid = 1'b0;
        n = 0;
        while (pa_bias !== tgt)
        begin
            @(posedge pclk);
            if (pa_bias != 4'h0 && pa_bias != 4'hf)
                mid = 1'b1;
            n = n + 1;
            if (n > 40)
                give_up;
        end
    end
    endtask
    task one_path(input [7:0] ta, input [7:0] tb, input [2:0] en, input [7:0] pw);
    begin
        apb(1'b1, 8'h5a, {24'h0, ta});
        apb(1'b1, 8'h5c, {24'h0, tb});
        apb(1'b1, 8'h11, {24'h0, en, 5'h1f});
        repeat (3) @(posedge pclk);
        check("pout", {24'h0, pw}, {24'h0, pout_dbm});
        check("paths", {29'h0, en}, {29'h0, rf_io_pin_en, boost_a_en, boost_b_en});
    end
    endtask
    task t_regs;
    begin
        check("dev rst", 32'h52, {18'h0, freq_deviation_word});
        check("gain rst", 32'h1, {29'h0, applied_front_gain});
        apb(1'b0, 8'h5a, 32'h0);
        check("tune_a", 32'h55, rdata);
        apb(1'b0, 8'hff, 32'h0);
        check("unmapped err", 32'h1, {31'h0, rerr});
        check("unmapped", 32'h0, rdata);
        apb(1'b1, 8'h05, 32'h1555);
        apb(1'b0, 8'h05, 32'h0);
        check("dev", 32'h1555, rdata);
        apb(1'b1, 8'h05, 32'h000b);
        repeat (2) @(posedge pclk);
        check("dev out", 32'h000b, {18'h0, freq_deviation_word});
    end
    endtask
    task t_power;
    begin
        tx_enable <= 1'b1;
        apb(1'b1, 8'h11, 32'h7f);
        apb(1'b1, 8'h13, 32'h0f);
        one_path(8'h5d, 8'h7c, 3'b011, 8'h14);
        check("imax", 32'h78, {24'h0, current_limit_ma});
        check("clamp", 32'h0, {31'h0, current_clamp_en});
        apb(1'b1, 8'h13, 32'h1b);
        one_path(8'h55, 8'h70, 3'b011, 8'h11);
        one_path(8'h55, 8'h70, 3'b010, 8'h0d);
        one_path(8'h55, 8'h70, 3'b100, 8'h0d);
        check("imax", 32'h64, {24'h0, current_limit_ma});
        check("clamp", 32'h1, {31'h0, current_clamp_en});
        tx_enable <= 1'b0;
    end
    endtask
    task t_stream;
    begin
        apb(1'b1, 8'h02, 32'h01);
        for (k = 1; k < 4; k = k + 1)
        begin
            apb(1'b1, 8'h12, k << 5);
            repeat (2) @(posedge pclk);
            check("bt", k, {30'h0, gauss_bt_sel});
        end
        stream_en <= 1'b1;
        tx_enable <= 1'b1;
        for (k = 0; k < 5; k = k + 1)
        begin
            wait_edges(40);
            b = data_in;
            repeat (2) @(posedge pclk);
            check("tx bit", {31'h0, b}, {31'h0, tx_data_out});
            if (k > 0)
                check("bit period", 32'd17, n + 3);
        end
        tx_enable <= 1'b0;
        stream_en <= 1'b0;
    end
    endtask
    task t_ook;
    begin
        apb(1'b1, 8'h02, 32'h02);
        apb(1'b1, 8'h12, 32'h00);
        apb(1'b1, 8'h11, 32'h9f);
        tx_enable <= 1'b1;
        level <= 1'b1;
        ramp(4'hf);
        check("abrupt on", 32'h0, {31'h0, mid});
        level <= 1'b0;
        ramp(4'h0);
        check("abrupt off", 32'h0, {31'h0, mid});
        tx_enable <= 1'b0;
        apb(1'b1, 8'h12, 32'h20);
        tx_enable <= 1'b1;
        level <= 1'b1;
        ramp(4'hf);
        check("ramp up", 32'h1, {31'h0, mid});
        level <= 1'b0;
        ramp(4'h0);
        check("ramp down", 32'h1, {31'h0, mid});
        tx_enable <= 1'b0;
    end
    endtask
    task sample(input [7:0] v);
    begin
        @(posedge pclk);
        rssi_value <= v;
        rssi_strobe <= 1'b1;
        @(posedge pclk);
        rssi_strobe <= 1'b0;
    end
    endtask
    task pkt_end;
    begin
        @(posedge pclk);
        packet_done <= 1'b1;
        @(posedge pclk);
        packet_done <= 1'b0;
        repeat (20) @(posedge pclk);
        check("frozen", 32'h0, {31'h0, rx_waiting});
    end
    endtask
    task t_agc;
    begin
        rx_enable <= 1'b1;
        apb(1'b1, 8'h18, 32'h80);
        repeat (2) @(posedge pclk);
        check("zin", 32'h1, {31'h0, lna_impedance_sel});
        for (k = 1; k < 7; k = k + 1)
        begin
            apb(1'b1, 8'h18, k << 3);
            repeat (3) @(posedge pclk);
            check("gain", k, {29'h0, applied_front_gain});
        end
        apb(1'b1, 8'h18, 32'h00);
        apb(1'b1, 8'h29, 32'h80);
        sample(8'h40);
        sample(8'h90);
        sample(8'h40);
        repeat (4) @(posedge pclk);
        check("wait", 32'h1, {31'h0, rx_waiting});
        sample(8'h40);
        repeat (4) @(posedge pclk);
        check("frozen", 32'h0, {31'h0, rx_waiting});
        pkt_end;
        apb(1'b1, 8'h3d, 32'h04);
        repeat (3) @(posedge pclk);
        check("wait", 32'h1, {31'h0, rx_waiting});
        sample(8'h40);
        sample(8'h40);
        apb(1'b1, 8'h3d, 32'h22);
        pkt_end;
        fifo_empty <= 1'b1;
        n = 0;
        while (rx_waiting !== 1'b1)
        begin
            @(posedge pclk);
            n = n + 1;
            if (n > 30)
                give_up;
        end
        check("gap", 32'h1, {31'h0, n >= 4});
    end
    endtask
    initial
    begin
        repeat (100000) @(posedge pclk);
        give_up;
    end
    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_power;
        t_stream;
        t_ook;
        t_agc;
        complete_run;
    end
endmodule // test_radio_ctrl
